/* rtl/ceq_pkg.sv */
// Package for the channel enable and receive equalizer boost register bank.
// Assumes byte-wide register access from a management-interface slave.
package ceq_pkg;
  localparam int CEQ_NUM_CH = 3;
  localparam int CEQ_BOOST_W = 9;
  localparam logic [7:0] CEQ_CH2_CTRL_ADDR = 8'h15;
  localparam logic [7:0] CEQ_CH2_LOW_ADDR = 8'h16;
  localparam logic [7:0] CEQ_CH1_CTRL_ADDR = 8'h17;
  localparam logic [7:0] CEQ_CH1_LOW_ADDR = 8'h18;
  localparam logic [7:0] CEQ_CH0_CTRL_ADDR = 8'h19;
  localparam logic [7:0] CEQ_CH0_LOW_ADDR = 8'h1A;
  localparam int CEQ_ENABLE_BIT = 4;
  localparam int CEQ_BOOST_MSB_BIT = 0;
  localparam logic [7:0] CEQ_CTRL_RESET = 8'h10;
  localparam logic [7:0] CEQ_LOW_RESET = 8'h00;
  localparam logic [7:0] CEQ_UNMAPPED_DATA = 8'h00;
  localparam logic [8:0] CEQ_PIN_BOOST_MAX = 9'h03F;
endpackage

/* rtl/ceq_regs.sv */
// Channel enable and receive equalizer boost registers for channels 2..0.
// Assumes a management slave gives byte writes/reads on i_clk; pins are async.
`timescale 1ns/1ps
`default_nettype none
// How it works
// (R1) Control bit 4 enables the channel; resets to 1.
// (R2) Boost is 9 bits: control bit 0 is MSB, next register the low byte.
// (R3) Pin boost levels 0..7 map to 000h,001h,003h,007h,00Fh,01Fh,02Fh,03Fh.
// (R4) Host should program only the sixteen recommended boost codes.
// (R5) Codes above 03Fh reachable only through the registers, never from pins.
// (R6) Register values govern only while override is set; otherwise pins govern.
// (R7) Reserved control bits store writes, reset to zero, affect nothing.
module ceq_regs (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_override,
  input wire logic [ceq_pkg::CEQ_NUM_CH-1:0] i_pin_enable,
  input wire logic [2:0] i_pin_boost_select,
  output logic [7:0] o_rd_data,
  output logic [ceq_pkg::CEQ_NUM_CH-1:0] o_ch_enable,
  output logic [ceq_pkg::CEQ_NUM_CH-1:0][ceq_pkg::CEQ_BOOST_W-1:0] o_ch_boost
);
  import ceq_pkg::*;

  function automatic logic [8:0] pin_to_code(input logic [2:0] sel);
    unique case (sel) // [R3] [R5]
      3'h0: pin_to_code = 9'h000;
      3'h1: pin_to_code = 9'h001;
      3'h2: pin_to_code = 9'h003;
      3'h3: pin_to_code = 9'h007;
      3'h4: pin_to_code = 9'h00F;
      3'h5: pin_to_code = 9'h01F;
      3'h6: pin_to_code = 9'h02F;
      3'h7: pin_to_code = 9'h03F;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int PW = CEQ_NUM_CH + 3;
  localparam logic [PW-1:0] PIN_RESET = {{CEQ_NUM_CH{1'b1}}, 3'h0};
  logic [PW-1:0] pin_s1;
  logic [PW-1:0] pin_s2;
  logic [PW-1:0] pin_s3;
  logic [PW-1:0] pin_stable;
  // Only bits where stages 2 and 3 agree update, so a glitch is dropped
  wire [PW-1:0] pin_agree = ~(pin_s2 ^ pin_s3);
  wire [PW-1:0] next_pin_stable = (pin_agree & pin_s3) | (~pin_agree & pin_stable);

  // Stages restart from idle so a short reset never lets X reach the agreement test
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      pin_s1 <= PIN_RESET;
      pin_s2 <= PIN_RESET;
      pin_s3 <= PIN_RESET;
      pin_stable <= PIN_RESET;
    end
    else
    begin
      pin_s1 <= {i_pin_enable, i_pin_boost_select};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_stable <= next_pin_stable;
    end
  end

  wire [CEQ_NUM_CH-1:0] pin_en = pin_stable[PW-1:3];
  wire [8:0] pin_code = pin_to_code(pin_stable[2:0]);

  ////////////////////////////////////////////////////////////////////////////
  // Register file; index 0..2 is channel number
  logic [CEQ_NUM_CH-1:0][7:0] ctrl;
  logic [CEQ_NUM_CH-1:0][7:0] low;
  wire [CEQ_NUM_CH-1:0][7:0] ctrl_addr = {CEQ_CH2_CTRL_ADDR, CEQ_CH1_CTRL_ADDR, CEQ_CH0_CTRL_ADDR};
  wire [CEQ_NUM_CH-1:0][7:0] low_addr = {CEQ_CH2_LOW_ADDR, CEQ_CH1_LOW_ADDR, CEQ_CH0_LOW_ADDR};
  logic [CEQ_NUM_CH-1:0] hit_ctrl;
  logic [CEQ_NUM_CH-1:0] hit_low;
  logic [7:0] next_rd_data;

  always_comb
  begin
    next_rd_data = CEQ_UNMAPPED_DATA;
    for (int c = 0; c < CEQ_NUM_CH; c++)
    begin
      hit_ctrl[c] = (i_addr == ctrl_addr[c]);
      hit_low[c] = (i_addr == low_addr[c]);
      if (hit_ctrl[c])
        next_rd_data = ctrl[c];
      if (hit_low[c])
        next_rd_data = low[c];
    end
  end

  always_ff @(posedge i_clk)
  begin
    for (int c = 0; c < CEQ_NUM_CH; c++)
    begin
      if (!i_resetn)
      begin
        ctrl[c] <= CEQ_CTRL_RESET; // [R1] [R7]
        low[c] <= CEQ_LOW_RESET; // [R2]
      end
      else
      begin
        // Reserved bits are stored whole, read back, and feed nothing
        if (i_wr_en && hit_ctrl[c])
          ctrl[c] <= i_wr_data; // [R7]
        if (i_wr_en && hit_low[c])
          low[c] <= i_wr_data; // [R2]
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      o_rd_data <= CEQ_UNMAPPED_DATA;
    else if (i_rd_en)
      o_rd_data <= next_rd_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel settings: registers under override, pins otherwise
  logic [CEQ_NUM_CH-1:0] next_enable;
  logic [CEQ_NUM_CH-1:0][8:0] next_boost;

  always_comb
  begin
    for (int c = 0; c < CEQ_NUM_CH; c++)
    begin
      next_enable[c] = i_override ? ctrl[c][CEQ_ENABLE_BIT] : pin_en[c]; // [R1] [R6]
      next_boost[c] = i_override ? {ctrl[c][CEQ_BOOST_MSB_BIT], low[c]} : pin_code; // [R2] [R6]
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_ch_enable <= '1;
      o_ch_boost <= '0;
    end
    else
    begin
      o_ch_enable <= next_enable;
      o_ch_boost <= next_boost;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic past_reset;
  always_ff @(posedge i_clk)
  begin
    past_reset <= !i_resetn;
  end

  property p_reset_defaults;
    @(posedge i_clk) past_reset && i_resetn |-> ctrl[0] == CEQ_CTRL_RESET && ctrl[1] == CEQ_CTRL_RESET
      && ctrl[2] == CEQ_CTRL_RESET && low[0] == CEQ_LOW_RESET && low[1] == CEQ_LOW_RESET && low[2] == CEQ_LOW_RESET;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("bad control reset value"); // [R1]

  property p_reg_enable;
    @(posedge i_clk) disable iff (!i_resetn)
      i_override |=> o_ch_enable == {$past(ctrl[2][4]), $past(ctrl[1][4]), $past(ctrl[0][4])};
  endproperty
  a_reg_enable: assert property (p_reg_enable) else $error("enable not from registers"); // [R1]

  property p_reg_boost;
    @(posedge i_clk) disable iff (!i_resetn)
      i_override |=> o_ch_boost[1] == {$past(ctrl[1][0]), $past(low[1])};
  endproperty
  a_reg_boost: assert property (p_reg_boost) else $error("boost not from registers"); // [R2]

  property p_pin_code;
    @(posedge i_clk) disable iff (!i_resetn)
      !i_override && pin_stable[2:0] == 3'h6 |=> o_ch_boost[0] == 9'h02F;
  endproperty
  a_pin_code: assert property (p_pin_code) else $error("pin level six not 02Fh"); // [R3]

  property p_pin_limit;
    @(posedge i_clk) disable iff (!i_resetn)
      !i_override |=> o_ch_boost[2] <= CEQ_PIN_BOOST_MAX && o_ch_enable == $past(pin_en);
  endproperty
  a_pin_limit: assert property (p_pin_limit) else $error("pin mode out of range"); // [R5] [R6]

  property p_write_ctrl;
    @(posedge i_clk) disable iff (!i_resetn)
      i_wr_en && i_addr == CEQ_CH1_CTRL_ADDR ##1 i_rd_en && i_addr == CEQ_CH1_CTRL_ADDR
      |=> o_rd_data == $past(i_wr_data, 2);
  endproperty
  a_write_ctrl: assert property (p_write_ctrl) else $error("control readback mismatch"); // [R7]

  property p_reserved_inert;
    @(posedge i_clk) disable iff (!i_resetn)
      i_override && $stable(ctrl[0][4]) && $stable(ctrl[0][0]) && $stable(low[0]) && $past(i_override)
      |=> $stable(o_ch_boost[0]) && $stable(o_ch_enable[0]);
  endproperty
  a_reserved_inert: assert property (p_reserved_inert) else $error("reserved bits changed channel"); // [R7]

  property p_reset_outputs;
    @(posedge i_clk) !i_resetn |=> o_ch_enable == '1 && o_ch_boost == '0;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("channel outputs not at reset value"); // [R1]

  property p_enable_write;
    @(posedge i_clk) disable iff (!i_resetn)
      i_wr_en && i_addr == CEQ_CH0_CTRL_ADDR |=> ctrl[0][CEQ_ENABLE_BIT] == $past(i_wr_data[CEQ_ENABLE_BIT]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable bit not stored"); // [R1]

  property p_low_write;
    @(posedge i_clk) disable iff (!i_resetn)
      i_wr_en && i_addr == CEQ_CH1_LOW_ADDR |=> low[1] == $past(i_wr_data);
  endproperty
  a_low_write: assert property (p_low_write) else $error("low boost byte not stored"); // [R2]

  property p_pin_enable_off;
    @(posedge i_clk) disable iff (!i_resetn)
      !i_override && !pin_en[1] |=> !o_ch_enable[1];
  endproperty
  a_pin_enable_off: assert property (p_pin_enable_off) else $error("pin off did not disable channel"); // [R6]

  property p_read_hold;
    @(posedge i_clk) disable iff (!i_resetn)
      !i_rd_en |=> $stable(o_rd_data);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data changed without a read"); // [R7]
endmodule
`default_nettype wire

/* verification/ceq_host.sv */
// Management host model issuing byte register cycles.
// Assumes the device samples strobes on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module ceq_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rd_data,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wr_data
);
  // The boost task programs only these codes
  logic [8:0] rec [16] = '{9'h000, 9'h001, 9'h002, 9'h003, 9'h007, 9'h015, 9'h00B, 9'h00F,
    9'h055, 9'h01F, 9'h02F, 9'h03F, 9'h0AA, 9'h07F, 9'h0BF, 9'h0FF};
  initial
  begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wr_data = 8'h00;
  end
  task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge i_clk);
    o_wr_en <= w;
    o_rd_en <= !w;
    o_addr <= a;
    o_wr_data <= d;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_rd_en <= 1'b0;
  end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
  begin
    cyc(1'b0, a, 8'h00);
    #1 d = i_rd_data;
  end
  endtask
  // Write then read the same register on consecutive edges
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] v, output logic [7:0] d);
  begin
    @(posedge i_clk);
    o_wr_en <= 1'b1;
    o_addr <= a;
    o_wr_data <= v;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_rd_en <= 1'b1;
    @(posedge i_clk);
    o_rd_en <= 1'b0;
    #1 d = i_rd_data;
  end
  endtask
  // Enable kept on, boost MSB in bit 0
  task automatic boost(input int c, input int i);
  begin
    cyc(1'b1, 8'h19 - 8'(2 * c), {7'h08, rec[i][8]});
    cyc(1'b1, 8'h1A - 8'(2 * c), rec[i][7:0]);
  end
  endtask
endmodule
`default_nettype wire

/* verification/channel_enable_eq_regs_tb.sv */
// Self-checking bench for the channel enable and boost registers.
// Assumes the host model and the register block share one clock.
`timescale 1ns/1ps
`default_nettype none
module channel_enable_eq_regs_tb;
  import ceq_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ovr = 1'b0;
  logic [2:0] pin_en = 3'h7;
  logic [2:0] pin_sel = 3'h0;
  logic wr_en, rd_en;
  logic [7:0] addr, wr_data, rd_data, d;
  logic [2:0] ch_en;
  logic [2:0][8:0] ch_boost;
  logic [8:0] pin_tab [8] = '{9'h000, 9'h001, 9'h003, 9'h007, 9'h00F, 9'h01F, 9'h02F, 9'h03F};
  int failures = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  ceq_host host (.i_clk(clk), .i_rd_data(rd_data), .o_wr_en(wr_en), .o_rd_en(rd_en),
    .o_addr(addr), .o_wr_data(wr_data));
  ceq_regs DUT (.i_clk(clk), .i_resetn(resetn), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr),
    .i_wr_data(wr_data), .i_override(ovr), .i_pin_enable(pin_en),
    .i_pin_boost_select(pin_sel), .o_rd_data(rd_data), .o_ch_enable(ch_en), .o_ch_boost(ch_boost));
  task automatic chk(input string n, input logic [8:0] got, input logic [8:0] exp);
  begin
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  end
  endtask
  task automatic end_of_test();
  begin
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  task automatic w(input int n);
  begin
    repeat (n) @(posedge clk);
    #1;
  end
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    for (int c = 0; c < 3; c++)
    begin
      host.rd(CEQ_CH0_CTRL_ADDR - 8'(2 * c), d);
      chk("ctrl", {1'b0, d}, {1'b0, CEQ_CTRL_RESET});
      host.rd(CEQ_CH0_LOW_ADDR - 8'(2 * c), d);
      chk("low", {1'b0, d}, 9'h000);
    end
    chk("en", {6'h00, ch_en}, 9'h007);
    host.rd(8'h20, d);
    chk("unmapped", {1'b0, d}, 9'h000);
    ovr <= 1'b1;
    // Reserved bits set, channel off
    host.cyc(1'b1, CEQ_CH0_CTRL_ADDR, 8'hE1);
    host.rd(CEQ_CH0_CTRL_ADDR, d);
    chk("resv", {1'b0, d}, 9'h0E1);
    chk("en0", {8'h00, ch_en[0]}, 9'h000);
    chk("b0", ch_boost[0], 9'h100);
    // Back-to-back write and read of one control register
    host.wr_rd(CEQ_CH1_CTRL_ADDR, 8'hB0, d);
    chk("wr_rd", {1'b0, d}, 9'h0B0);
    for (int i = 0; i < 16; i++)
    begin
      host.boost(1, i);
      w(2);
      chk("b1", ch_boost[1], host.rec[i]);
      chk("en1", {8'h00, ch_en[1]}, 9'h001);
    end
    // Pins govern again, register state ignored
    ovr <= 1'b0;
    pin_en <= 3'h5;
    for (int s = 0; s < 8; s++)
    begin
      pin_sel <= 3'(s);
      w(8);
      chk("pin2", ch_boost[2], pin_tab[s]);
      chk("pin0", ch_boost[0], pin_tab[s]);
    end
    chk("pin_en", {6'h00, ch_en}, 9'h005);
    // Reset mid-run brings written registers back to defaults
    resetn <= 1'b0;
    w(2);
    resetn <= 1'b1;
    host.rd(CEQ_CH1_LOW_ADDR, d);
    chk("rst_low", {1'b0, d}, {1'b0, CEQ_LOW_RESET});
    host.rd(CEQ_CH0_CTRL_ADDR, d);
    chk("rst_ctrl", {1'b0, d}, {1'b0, CEQ_CTRL_RESET});
    end_of_test();
  end
  // Hang guard
  initial
  begin
    #100000;
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
